// *** src/pgot_top.sv ***
/*
  Top of the per-sample gain and offset trim block for channels six and
  seven: AHB-Lite register slave, trim settings and two datapath lanes.
  Assumes one clock, synchronous sample streams and word-only accesses.
*/
`timescale 1ns/1ps
module pgot_top #(
  parameter int SAMPLE_W = pgot_pkg::PGOT_SAMPLE_W
) (
  // Clock and reset
  input  logic                I_MCLK,
  input  logic                I_RESET_N,
  // AHB-Lite slave
  input  logic                I_HSEL,
  input  logic [31:0]         I_HADDR,
  input  logic [1:0]          I_HTRANS,
  input  logic                I_HWRITE,
  input  logic [2:0]          I_HSIZE,
  input  logic [31:0]         I_HWDATA,
  input  logic                I_HREADY,
  output logic [31:0]         O_HRDATA,
  output logic                O_HREADYOUT,
  output logic                O_HRESP,
  // Channel six stream
  input  logic                I_CH6_VALID,
  input  logic                I_CH6_FIRST,
  input  logic [SAMPLE_W-1:0] I_CH6_SAMPLE,
  output logic                O_CH6_VALID,
  output logic [SAMPLE_W-1:0] O_CH6_SAMPLE,
  // Channel seven stream
  input  logic                I_CH7_VALID,
  input  logic                I_CH7_FIRST,
  input  logic [SAMPLE_W-1:0] I_CH7_SAMPLE,
  output logic                O_CH7_VALID,
  output logic [SAMPLE_W-1:0] O_CH7_SAMPLE
);
  import pgot_pkg::*;

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr_pend;
    logic [5:0]  wr_idx;
    logic [15:0] ch6_odd_sample_trim;
    logic [15:0] ch6_even_sample_trim;
    logic [15:0] ch7_odd_sample_trim;
    logic [15:0] ch7_even_sample_trim;
    logic        gain_correction_enable;
    logic        offset_correction_enable;
    logic        clip6;
    logic        clip7;
    logic [31:0] hrdata;
    logic        hreadyout;
  } pgot_top_s;

  pgot_top_s   q;
  pgot_top_s   n;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        odd6;
  logic        odd7;
  logic        clip6_ev;
  logic        clip7_ev;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Assert at once, release two edges later so no flop sees a runt
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Reserved bits of the config and status words read as zero
  function automatic logic [31:0] read_word(input pgot_top_s s,
                                            input logic [5:0] idx,
                                            input logic o6,
                                            input logic o7);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      PGOT_IDX_CFG: begin
        w[PGOT_CFG_GAIN] = s.gain_correction_enable;
        w[PGOT_CFG_OFS]  = s.offset_correction_enable;
      end
      PGOT_IDX_CH6_ODD:  w[15:0] = s.ch6_odd_sample_trim;
      PGOT_IDX_CH6_EVEN: w[15:0] = s.ch6_even_sample_trim;
      PGOT_IDX_CH7_ODD:  w[15:0] = s.ch7_odd_sample_trim;
      PGOT_IDX_CH7_EVEN: w[15:0] = s.ch7_even_sample_trim;
      PGOT_IDX_STATUS: begin
        w[PGOT_ST_ODD6]  = o6;
        w[PGOT_ST_ODD7]  = o7;
        w[PGOT_ST_CLIP6] = s.clip6;
        w[PGOT_ST_CLIP7] = s.clip7;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Write data lands at the end of the data phase; a read that follows
  // at once is served from the next-state copy, so it sees that write
  always_comb begin
    logic accept;
    logic mapped;
    accept = 1'b0;
    mapped = 1'b0;
    n = q;
    n.hreadyout = 1'b1;
    if (q.wr_pend) begin
      case (q.wr_idx)
        PGOT_IDX_CFG: begin
          n.gain_correction_enable   = I_HWDATA[PGOT_CFG_GAIN];
          n.offset_correction_enable = I_HWDATA[PGOT_CFG_OFS];
        end
        // All sixteen low bits kept, bit ten included, as software wrote them
        PGOT_IDX_CH6_ODD:  n.ch6_odd_sample_trim  = I_HWDATA[15:0];
        PGOT_IDX_CH6_EVEN: n.ch6_even_sample_trim = I_HWDATA[15:0];
        PGOT_IDX_CH7_ODD:  n.ch7_odd_sample_trim  = I_HWDATA[15:0];
        PGOT_IDX_CH7_EVEN: n.ch7_even_sample_trim = I_HWDATA[15:0];
        PGOT_IDX_STATUS: begin
          if (I_HWDATA[PGOT_ST_CLIP6]) begin
            n.clip6 = 1'b0;
          end
          if (I_HWDATA[PGOT_ST_CLIP7]) begin
            n.clip7 = 1'b0;
          end
        end
        default: n.wr_pend = 1'b0;
      endcase
    end
    // Clip events come after the clear so a same-cycle event survives
    if (clip6_ev) begin
      n.clip6 = 1'b1;
    end
    if (clip7_ev) begin
      n.clip7 = 1'b1;
    end
    // Address phase
    accept = I_HSEL && I_HTRANS[1] && I_HREADY;
    mapped = (I_HADDR[31:8] == 24'h000000) && (I_HADDR[1:0] == 2'h0);
    n.wr_pend = accept && I_HWRITE && mapped;
    n.wr_idx = I_HADDR[7:2];
    if (accept && !I_HWRITE && mapped) begin
      n.hrdata = read_word(n, I_HADDR[7:2], odd6, odd7);
    end else begin
      n.hrdata = 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ch6_odd_sample_trim  <= PGOT_TRIM_RST;
      q.ch6_even_sample_trim <= PGOT_TRIM_RST;
      q.ch7_odd_sample_trim  <= PGOT_TRIM_RST;
      q.ch7_even_sample_trim <= PGOT_TRIM_RST;
      q.gain_correction_enable   <= PGOT_CFG_RST[PGOT_CFG_GAIN];
      q.offset_correction_enable <= PGOT_CFG_RST[PGOT_CFG_OFS];
      q.hreadyout <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Zero wait states and always OKAY: HREADYOUT from a fixed flop, HRESP tied low
  assign O_HRDATA    = q.hrdata;
  assign O_HREADYOUT = q.hreadyout;
  assign O_HRESP     = 1'b0;

  // ----------------------------------------------------------------
  // Datapath lanes
  // ----------------------------------------------------------------
  // Each lane gets both of its settings; the lane picks by parity
  pgot_trim_lane #(
    .SAMPLE_W (SAMPLE_W)
  ) u_lane6 (
    .clk         (I_MCLK),
    .rst_n       (rst_n),
    .i_gain_en   (q.gain_correction_enable),
    .i_offset_en (q.offset_correction_enable),
    .i_odd_trim  (q.ch6_odd_sample_trim),
    .i_even_trim (q.ch6_even_sample_trim),
    .i_valid     (I_CH6_VALID),
    .i_first     (I_CH6_FIRST),
    .i_sample    (I_CH6_SAMPLE),
    .o_valid     (O_CH6_VALID),
    .o_sample    (O_CH6_SAMPLE),
    .o_clip      (clip6_ev),
    .o_next_odd  (odd6)
  );

  pgot_trim_lane #(
    .SAMPLE_W (SAMPLE_W)
  ) u_lane7 (
    .clk         (I_MCLK),
    .rst_n       (rst_n),
    .i_gain_en   (q.gain_correction_enable),
    .i_offset_en (q.offset_correction_enable),
    .i_odd_trim  (q.ch7_odd_sample_trim),
    .i_even_trim (q.ch7_even_sample_trim),
    .i_valid     (I_CH7_VALID),
    .i_first     (I_CH7_FIRST),
    .i_sample    (I_CH7_SAMPLE),
    .o_valid     (O_CH7_VALID),
    .o_sample    (O_CH7_SAMPLE),
    .o_clip      (clip7_ev),
    .o_next_odd  (odd7)
  );

endmodule

// *** src/pgot_pkg.sv ***
/*
  Shared constants of the per-sample gain and offset trim block: register
  indices, field positions, reset values, gain table and bus codes.
  Assumes a 32-bit AHB-Lite register bus and 14-bit signed samples.
*/
// Notes on behaviour
// - gain applied only while gain enable set
// - gain code N gives N times 0.2 dB
// - offset subtracted only while offset enable set
// - offset field is two's complement, negatives add
// - one offset count equals one 14-bit LSB
// - odd setting acts only on odd samples
// - even setting acts only on even samples
// - reset clears every trim field to zero
package pgot_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PGOT_DATA_W   = 32;
  localparam int PGOT_REG_W    = 16;
  localparam int PGOT_SAMPLE_W = 14;
  localparam int PGOT_OFS_W    = 10;
  localparam int PGOT_GCODE_W  = 5;
  localparam int PGOT_COEF_W   = 14;
  localparam int PGOT_IDX_W    = 6;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] PGOT_IDX_CFG      = 6'h03;
  localparam logic [5:0] PGOT_IDX_CH6_ODD  = 6'h1B;
  localparam logic [5:0] PGOT_IDX_CH6_EVEN = 6'h1C;
  localparam logic [5:0] PGOT_IDX_CH7_ODD  = 6'h1D;
  localparam logic [5:0] PGOT_IDX_CH7_EVEN = 6'h1E;
  localparam logic [5:0] PGOT_IDX_STATUS   = 6'h3F;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PGOT_GAIN_MSB   = 15;
  localparam int PGOT_GAIN_LSB   = 11;
  localparam int PGOT_RSV_BIT    = 10;
  localparam int PGOT_OFS_MSB    = 9;
  localparam int PGOT_OFS_LSB    = 0;
  localparam int PGOT_CFG_GAIN   = 12;
  localparam int PGOT_CFG_OFS    = 8;
  localparam int PGOT_ST_ODD6    = 0;
  localparam int PGOT_ST_ODD7    = 1;
  localparam int PGOT_ST_CLIP6   = 2;
  localparam int PGOT_ST_CLIP7   = 3;
  localparam logic [15:0] PGOT_TRIM_RST = 16'h0000;
  localparam logic [15:0] PGOT_CFG_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Gain: Q2.12 linear factor of 10^(N*0.2/20), N = 0..31
  // ----------------------------------------------------------------
  localparam int PGOT_GAIN_FRAC = 12;
  localparam logic [13:0] PGOT_GAIN_UNITY = 14'h1000;
  localparam logic [31:0][13:0] PGOT_GAIN_TAB = {
    14'h20AB, 14'h1FED, 14'h1F33, 14'h1E7D, 14'h1DCB, 14'h1D1D, 14'h1C74, 14'h1BCE,
    14'h1B2C, 14'h1A8E, 14'h19F3, 14'h195C, 14'h18C8, 14'h1838, 14'h17AA, 14'h1721,
    14'h169A, 14'h1616, 14'h1595, 14'h1518, 14'h149D, 14'h1425, 14'h13AF, 14'h133C,
    14'h12CC, 14'h125F, 14'h11F4, 14'h118B, 14'h1125, 14'h10C1, 14'h105F, 14'h1000};

  // ----------------------------------------------------------------
  // Bus codes and latency
  // ----------------------------------------------------------------
  localparam logic [1:0] PGOT_HTRANS_NONSEQ = 2'h2;
  localparam int         PGOT_PIPE_LAT      = 2;

endpackage

// *** src/pgot_trim_lane.sv ***
/*
  One channel of the trim datapath: odd/even setting select, offset
  subtraction, gain scaling and saturation, two pipeline stages.
  Assumes samples are signed and synchronous to the clock.
*/
`timescale 1ns/1ps
module pgot_trim_lane #(
  parameter int SAMPLE_W = pgot_pkg::PGOT_SAMPLE_W
) (
  // Clock and reset
  input  logic                clk,
  input  logic                rst_n,
  // Global enables and settings
  input  logic                i_gain_en,
  input  logic                i_offset_en,
  input  logic [15:0]         i_odd_trim,
  input  logic [15:0]         i_even_trim,
  // Sample stream in
  input  logic                i_valid,
  input  logic                i_first,
  input  logic [SAMPLE_W-1:0] i_sample,
  // Sample stream out
  output logic                o_valid,
  output logic [SAMPLE_W-1:0] o_sample,
  output logic                o_clip,
  output logic                o_next_odd
);
  import pgot_pkg::*;

  localparam int DW = SAMPLE_W + 1;
  localparam int PW = SAMPLE_W + 16;
  localparam logic signed [PW-1:0] SMAX = PW'((1 <<< (SAMPLE_W - 1)) - 1);
  localparam logic signed [PW-1:0] SMIN = -PW'(1 <<< (SAMPLE_W - 1));

  typedef struct packed {
    logic                odd;
    logic                s1_valid;
    logic [DW-1:0]       s1_diff;
    logic [13:0]         s1_coef;
    logic                out_valid;
    logic [SAMPLE_W-1:0] out_sample;
    logic                out_clip;
  } pgot_lane_s;

  pgot_lane_s q;
  pgot_lane_s n;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Setting is picked per sample so odd and even never mix
  always_comb begin
    logic            is_odd;
    logic [15:0]     sel;
    logic [DW-1:0]   ofs;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scl;
    is_odd = 1'b0;
    sel = 16'h0000;
    ofs = '0;
    prod = '0;
    scl = '0;
    n = q;
    is_odd = i_first ? 1'b0 : q.odd;
    sel = is_odd ? i_odd_trim : i_even_trim;
    if (i_valid) begin
      n.odd = ~is_odd;
    end
    // Sign extension makes a negative offset add to the sample
    ofs = DW'($signed(sel[PGOT_OFS_MSB:PGOT_OFS_LSB]));
    n.s1_valid = i_valid;
    n.s1_diff = DW'($signed(i_sample)) - (i_offset_en ? ofs : '0);
    n.s1_coef = i_gain_en ? PGOT_GAIN_TAB[sel[PGOT_GAIN_MSB:PGOT_GAIN_LSB]]
                          : PGOT_GAIN_UNITY;
    // Round half up, then clamp; a wrap would be far worse than a clip
    prod = PW'($signed(q.s1_diff)) * PW'($signed({1'b0, q.s1_coef}));
    scl = (prod + PW'(1 <<< (PGOT_GAIN_FRAC - 1))) >>> PGOT_GAIN_FRAC;
    n.out_valid = q.s1_valid;
    n.out_clip = 1'b0;
    if (scl > SMAX) begin
      n.out_sample = SMAX[SAMPLE_W-1:0];
      n.out_clip = q.s1_valid;
    end else if (scl < SMIN) begin
      n.out_sample = SMIN[SAMPLE_W-1:0];
      n.out_clip = q.s1_valid;
    end else begin
      n.out_sample = scl[SAMPLE_W-1:0];
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_valid    = q.out_valid;
  assign o_sample   = q.out_sample;
  assign o_clip     = q.out_clip;
  assign o_next_odd = q.odd;

endmodule

// *** bench/pgot_props.sv ***
/*
  Checker for the trim block top: bus shadow, readback and stream timing.
  Assumes one clock and HREADY tied to HREADYOUT.
*/
`timescale 1ns/1ps
module pgot_props
  import pgot_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset
  input wire logic                I_MCLK,
  input wire logic                I_RESET_N,
  // Bus
  input wire logic                I_HSEL,
  input wire logic [31:0]         I_HADDR,
  input wire logic [1:0]          I_HTRANS,
  input wire logic                I_HWRITE,
  input wire logic [31:0]         I_HWDATA,
  input wire logic                I_HREADY,
  input wire logic [31:0]         O_HRDATA,
  input wire logic                O_HREADYOUT,
  input wire logic                O_HRESP,
  // Streams
  input wire logic                I_CH6_VALID,
  input wire logic [SAMPLE_W-1:0] I_CH6_SAMPLE,
  input wire logic                O_CH6_VALID,
  input wire logic [SAMPLE_W-1:0] O_CH6_SAMPLE,
  input wire logic                I_CH7_VALID,
  input wire logic [SAMPLE_W-1:0] I_CH7_SAMPLE,
  input wire logic                O_CH7_VALID,
  input wire logic [SAMPLE_W-1:0] O_CH7_SAMPLE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  logic        a_wr;
  logic        a_rd;
  logic [5:0]  a_idx;
  logic [15:0] cfg;
  logic [15:0] trim [4];
  logic        in_trim;
  logic        byp;
  assign in_trim = a_idx >= PGOT_IDX_CH6_ODD && a_idx <= PGOT_IDX_CH7_EVEN;
  assign byp = !cfg[PGOT_CFG_GAIN] && !cfg[PGOT_CFG_OFS];
  // ----------------------------------------------------------------
  // Shadow of the registers; misaligned words map to index 0, unused
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      a_wr <= 1'b0;
      a_rd <= 1'b0;
      a_idx <= 6'h00;
      cfg <= 16'h0000;
      for (int i = 0; i < 4; i++) trim[i] <= 16'h0000;
    end else begin
      if (a_wr && O_HREADYOUT && a_idx == PGOT_IDX_CFG) cfg <= I_HWDATA[15:0] & 16'h1100;
      if (a_wr && O_HREADYOUT && in_trim) trim[2'(a_idx - PGOT_IDX_CH6_ODD)] <= I_HWDATA[15:0];
      if (I_HREADY) begin
        a_wr <= I_HSEL && I_HTRANS[1] && I_HWRITE;
        a_rd <= I_HSEL && I_HTRANS[1] && !I_HWRITE;
        a_idx <= (I_HADDR[31:8] == 24'h0 && I_HADDR[1:0] == 2'h0) ? I_HADDR[7:2] : 6'h00;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s6_out; ##2 O_CH6_VALID; endsequence
  sequence s7_out; ##2 O_CH7_VALID; endsequence
  chk_ch6_latency: assert property (I_CH6_VALID |-> s6_out)
    else $error("ch6 output strobe late or missing");
  chk_ch7_latency: assert property (I_CH7_VALID |-> s7_out)
    else $error("ch7 output strobe late or missing");
  chk_ch6_no_spur: assert property (O_CH6_VALID |-> $past(I_CH6_VALID, 2))
    else $error("ch6 output strobe without input");
  chk_ch7_no_spur: assert property (O_CH7_VALID |-> $past(I_CH7_VALID, 2))
    else $error("ch7 output strobe without input");
  chk_ch6_bypass: assert property (I_CH6_VALID && byp |->
    ##2 O_CH6_SAMPLE == $past(I_CH6_SAMPLE, 2))
    else $error("ch6 sample altered with corrections off");
  chk_ch7_bypass: assert property (I_CH7_VALID && byp |->
    ##2 O_CH7_SAMPLE == $past(I_CH7_SAMPLE, 2))
    else $error("ch7 sample altered with corrections off");
  chk_trim_read: assert property (a_rd && in_trim |->
    O_HRDATA == {16'h0, trim[2'(a_idx - PGOT_IDX_CH6_ODD)]})
    else $error("trim register readback differs");
  chk_cfg_read: assert property (a_rd && a_idx == PGOT_IDX_CFG |->
    O_HRDATA == {16'h0, cfg})
    else $error("config readback differs");
  chk_unmapped_zero: assert property (a_rd && !in_trim && a_idx != PGOT_IDX_CFG &&
    a_idx != PGOT_IDX_STATUS |-> O_HRDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus stalled or error response");
endmodule
bind pgot_top pgot_props #(.SAMPLE_W(SAMPLE_W)) u_props (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
  .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
  .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP), .I_CH6_VALID(I_CH6_VALID), .I_CH6_SAMPLE(I_CH6_SAMPLE),
  .O_CH6_VALID(O_CH6_VALID), .O_CH6_SAMPLE(O_CH6_SAMPLE), .I_CH7_VALID(I_CH7_VALID),
  .I_CH7_SAMPLE(I_CH7_SAMPLE), .O_CH7_VALID(O_CH7_VALID), .O_CH7_SAMPLE(O_CH7_SAMPLE));

// *** bench/tb_per_sample_gain_offset_trim.sv ***
/*
  Self-checking bench for the trim block: register access, enables, parity.
  Assumes zero-wait bus answers are polled, never counted on.
*/
`timescale 1ns/1ps
module tb_per_sample_gain_offset_trim;
  import pgot_pkg::*;
  logic        I_MCLK = 1'b0, I_RESET_N = 1'b0, I_HSEL = 1'b0, I_HWRITE = 1'b0;
  logic [31:0] I_HADDR = 32'h0, I_HWDATA = 32'h0, O_HRDATA, rd;
  logic [1:0]  I_HTRANS = 2'h0;
  logic        I_CH6_VALID = 1'b0, I_CH6_FIRST = 1'b0, I_CH7_VALID = 1'b0, I_CH7_FIRST = 1'b0;
  logic [13:0] I_CH6_SAMPLE = 14'h0, I_CH7_SAMPLE = 14'h0, O_CH6_SAMPLE, O_CH7_SAMPLE;
  logic        O_HREADYOUT, O_HRESP, O_CH6_VALID, O_CH7_VALID;
  int          failures = 0, n_compared = 0;
  // Trim words keep bit ten clear; offsets span both signs and both ends
  logic [15:0] tv [4] = '{16'h2BFD, 16'hF864, 16'h0200, 16'h51FF};
  logic [15:0] cv [4] = '{16'h0000, 16'h0100, 16'h1000, 16'h1100};
  logic [13:0] sv [5] = '{14'h1234, 14'h3F00, 14'h1F40, 14'h0005, 14'h2000};

  always #10 I_MCLK = ~I_MCLK;

  pgot_top dut (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(3'h2), .I_HWDATA(I_HWDATA),
    .I_HREADY(O_HREADYOUT), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_CH6_VALID(I_CH6_VALID), .I_CH6_FIRST(I_CH6_FIRST), .I_CH6_SAMPLE(I_CH6_SAMPLE),
    .O_CH6_VALID(O_CH6_VALID), .O_CH6_SAMPLE(O_CH6_SAMPLE), .I_CH7_VALID(I_CH7_VALID),
    .I_CH7_FIRST(I_CH7_FIRST), .I_CH7_SAMPLE(I_CH7_SAMPLE), .O_CH7_VALID(O_CH7_VALID),
    .O_CH7_SAMPLE(O_CH7_SAMPLE));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is looked at mid-cycle so the edge's own updates never race it
  task automatic wait_rdy();
    @(negedge I_MCLK);
    while (O_HREADYOUT !== 1'b1) @(negedge I_MCLK);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    I_HSEL <= 1'b1;
    I_HADDR <= a;
    I_HTRANS <= PGOT_HTRANS_NONSEQ;
    I_HWRITE <= wr;
    wait_rdy();
    @(posedge I_MCLK);
    I_HSEL <= 1'b0;
    I_HTRANS <= 2'h0;
    I_HWDATA <= d;
    wait_rdy();
    rd = O_HRDATA;
    @(posedge I_MCLK);
  endtask

  // Expected corrected sample, saturated to 14 bits
  function automatic logic [13:0] model(input logic [13:0] s, input logic [15:0] t,
                                        input logic [15:0] c);
    int d;
    d = $signed(s);
    if (c[PGOT_CFG_OFS]) d = d - $signed(t[9:0]);
    if (c[PGOT_CFG_GAIN]) d = (d * int'(PGOT_GAIN_TAB[t[15:11]]) + 2048) >>> 12;
    if (d > 8191) d = 8191;
    if (d < -8192) d = -8192;
    return d[13:0];
  endfunction

  task automatic stream(input logic first, input logic [13:0] s, input logic [15:0] t6, t7, c);
    I_CH6_VALID <= 1'b1;
    I_CH7_VALID <= 1'b1;
    I_CH6_FIRST <= first;
    I_CH7_FIRST <= first;
    I_CH6_SAMPLE <= s;
    I_CH7_SAMPLE <= ~s;
    @(posedge I_MCLK);
    I_CH6_VALID <= 1'b0;
    I_CH7_VALID <= 1'b0;
    I_CH6_FIRST <= 1'b0;
    I_CH7_FIRST <= 1'b0;
    @(posedge I_MCLK);
    @(negedge I_MCLK);
    check({17'h0, O_CH6_VALID, O_CH6_SAMPLE}, {17'h0, 1'b1, model(s, t6, c)});
    check({17'h0, O_CH7_VALID, O_CH7_SAMPLE}, {17'h0, 1'b1, model(~s, t7, c)});
    @(posedge I_MCLK);
  endtask

  task automatic read_zero();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, (i == 0) ? 32'h0C : 32'h68 + 32'(4 * i), 32'h0);
      check(rd, 32'h0);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence of tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge I_MCLK);
    I_RESET_N <= 1'b1;
    repeat (3) @(posedge I_MCLK);
    read_zero();
    $display("reset value test done");
    // Write, then readback once the write's data phase is over; upper half must read zero
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'h6C + 32'(4 * i), {16'hA5A5, tv[i]});
      bus(1'b0, 32'h6C + 32'(4 * i), 32'h0);
      check(rd, {16'h0, tv[i]});
    end
    bus(1'b1, 32'h40, 32'hFFFF);
    bus(1'b0, 32'h40, 32'h0);
    check(rd, 32'h0);
    $display("register test done");
    // Five samples per round, so the next first marker must force even
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 32'h0C, {16'h0, cv[c]});
      bus(1'b0, 32'h0C, 32'h0);
      check(rd, {16'h0, cv[c]});
      for (int i = 0; i < 5; i++) begin
        stream(i == 0, sv[i], tv[i[0] ? 0 : 1],
               tv[i[0] ? 2 : 3], cv[c]);
      end
    end
    $display("datapath test done");
    // Five samples from an even start leave both lanes expecting odd;
    // the gain rounds drove both lanes past full scale, so both clips stick
    bus(1'b0, 32'hFC, 32'h0);
    check(rd, 32'h0000_000F);
    bus(1'b1, 32'hFC, 32'h0000_000C);
    bus(1'b0, 32'hFC, 32'h0);
    check(rd, 32'h0000_0003);
    $display("status test done");
    I_RESET_N <= 1'b0;
    repeat (2) @(posedge I_MCLK);
    I_RESET_N <= 1'b1;
    repeat (3) @(posedge I_MCLK);
    read_zero();
    $display("second reset test done");
    final_report();
  end

  // Whole run needs about 135 cycles
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule
